/* common/sram_tap_pkg.sv */
// Constants and types for the SRAM boundary-scan test access port.
// Assumes a single TAP with a 3-bit instruction register and no TAP reset pin.
package sram_tap_pkg;

  // ==========================================================
  // Instruction register
  localparam int IR_W = 3;
  localparam logic [2:0] INSN_EXTEST = 3'h0;
  localparam logic [2:0] INSN_IDCODE = 3'h1;
  localparam logic [2:0] INSN_OUTPUTS_OFF = 3'h2;
  localparam logic [2:0] INSN_RESERVED_A = 3'h3;
  localparam logic [2:0] INSN_PRELOAD = 3'h4;
  localparam logic [2:0] INSN_PRIVATE = 3'h5;
  localparam logic [2:0] INSN_RESERVED_B = 3'h6;
  localparam logic [2:0] INSN_BYPASS = 3'h7;
  // Capture pattern: low two bits 01, upper bit zero
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = INSN_IDCODE;

  // ==========================================================
  // Identification code fields
  localparam int ID_W = 32;
  // Arbitrary neutral values, not any real maker or part
  localparam logic [3:0] ID_REVISION = 4'h1;
  localparam logic [15:0] ID_CONFIG = 16'h0a5c;
  localparam logic [10:0] ID_VENDOR = 11'h2b6;
  localparam logic ID_PRESENCE = 1'b1;
  localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_CONFIG, ID_VENDOR, ID_PRESENCE};

  // ==========================================================
  // Boundary-scan register layout
  localparam int IN_W = 4;
  localparam int IO_W = 8;
  localparam int FILL_W = 2;
  localparam int BSR_W = IN_W + IO_W + FILL_W;
  localparam int IO_LSB = IN_W;
  localparam int FILL_LSB = IN_W + IO_W;
  localparam logic [1:0] FILL_DEFAULT = 2'h3;

  // ==========================================================
  // Timing
  localparam int CORE_CLK_NS = 100;
  localparam int TMS_RESET_EDGES = 5;
  localparam logic [2:0] TMS_RESET_EDGES_3 = 3'h5;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EXIT1_DR = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4,
    ST_UPD_DR = 4'hc,
    ST_SEL_IR = 4'hd,
    ST_CAP_IR = 4'hf,
    ST_SHIFT_IR = 4'he,
    ST_EXIT1_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_EXIT2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } tap_state_type;

  typedef enum logic [1:0] {
    DR_BYPASS = 2'h0,
    DR_IDENT = 2'h1,
    DR_BOUNDARY = 2'h3
  } dr_select_type;

endpackage

/* design/pin_sync.sv */
// Three-stage level synchroniser with agreement filter.
// Assumes inputs are levels that stay put long enough to be seen twice.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // ==========================================================
  // Stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // A change counts only once two later stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign agree[i] = (s2_q[i] == s3_q[i]);
    end
  endgenerate

  // One process owns q, so no bit has a second driver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= (agree & s3_q) | (~agree & q);
    end
  end

endmodule
`default_nettype wire

/* design/sram_tap.sv */
// Boundary-scan test access port of a synchronous burst SRAM.
// Assumes tck, tms, tdi from an external scan controller; rst is the power-up reset.
//
// How it works
// - Capture-IR loads 01 into low bits
// - Shift-IR moves instruction between tdi and tdo
// - New instruction acts only at Update-IR
// - Three-bit codes select the five instructions
// - BYPASS puts bypass cell in Shift-DR path
// - SAMPLE/PRELOAD captures pins, shifts boundary register
// - Pinless cells capture their fixed default
// - All-zero instruction register means EXTEST
// - EXTEST never blocks the SRAM input pins
// - EXTEST drives boundary values onto output drivers
// - EXTEST Capture-DR loads pin levels in parallel
// - IDCODE captures ID value, shifts it out
// - IDCODE active at power-up and Test-Logic-Reset
// - outputs_off floats outputs, captures and shifts ring
// - reserved_code codes behave exactly like BYPASS
// - Identification_code 32 bits, bit 0 first
// - Sample tms/tdi rising, change tdo falling
// - Five tms-high edges force Test-Logic-Reset
// - Bypass register is one flip-flop
`timescale 1ns/100ps
`default_nettype none
module sram_tap (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [sram_tap_pkg::IN_W-1:0] pad_in,
  input wire logic [sram_tap_pkg::IO_W-1:0] pad_io_in,
  output logic [sram_tap_pkg::IO_W-1:0] pad_io_out,
  output logic [sram_tap_pkg::IO_W-1:0] pad_io_oe_n,
  input wire logic [sram_tap_pkg::IO_W-1:0] core_dout,
  input wire logic core_doe
);
  import sram_tap_pkg::*;

  function automatic dr_select_type dr_select(input logic [2:0] insn);
    unique case (insn)
      INSN_EXTEST, INSN_OUTPUTS_OFF, INSN_PRELOAD: dr_select = DR_BOUNDARY;
      INSN_IDCODE: dr_select = DR_IDENT;
      default: dr_select = DR_BYPASS;
    endcase
  endfunction

  tap_state_type state_q;
  tap_state_type state_d;
  logic [2:0] ir_shift_q;
  logic [2:0] ir_q;
  logic extest_q;
  logic off_q;
  logic bypass_q;
  logic [ID_W-1:0] id_q;
  logic [BSR_W-1:0] bsr_q;
  logic [IO_W-1:0] bsr_upd_q;
  logic [IN_W-1:0] in_lvl;
  logic [IO_W-1:0] io_lvl;
  logic [BSR_W-1:0] capture_vec;
  dr_select_type sel;
  logic in_shift;
  logic serial_out;
  logic extest_s;
  logic off_s;
  logic [IO_W-1:0] upd_s;

  // ==========================================================
  // TAP state machine
  // Sixteen-state walk on tms
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // State follows tms on rising tck
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Instruction register
  // Capture pattern, then shift lsb first
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir_shift_q <= IR_CAPTURE;
    end else if (state_q == ST_CAP_IR) begin
      ir_shift_q <= IR_CAPTURE;
    end else if (state_q == ST_SHIFT_IR) begin
      ir_shift_q <= {tdi, ir_shift_q[2:1]};
    end
  end

  // Active code changes at Update-IR or reset
  // Falling edge, so the instruction changes mid-cycle in Update-IR
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      ir_q <= IR_RESET;
      extest_q <= 1'b0;
      off_q <= 1'b0;
    end else if (state_q == ST_RESET) begin
      ir_q <= IR_RESET;
      extest_q <= 1'b0;
      off_q <= 1'b0;
    end else if (state_q == ST_UPD_IR) begin
      ir_q <= ir_shift_q;
      extest_q <= (ir_shift_q == INSN_EXTEST);
      off_q <= (ir_shift_q == INSN_OUTPUTS_OFF);
    end
  end

  assign sel = dr_select(ir_q);

  // ==========================================================
  // Data registers
  // Single bypass flip-flop
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      bypass_q <= 1'b0;
    end else if (sel == DR_BYPASS && state_q == ST_CAP_DR) begin
      bypass_q <= 1'b0;
    end else if (sel == DR_BYPASS && state_q == ST_SHIFT_DR) begin
      bypass_q <= tdi;
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      id_q <= ID_VALUE;
    end else if (sel == DR_IDENT && state_q == ST_CAP_DR) begin
      id_q <= ID_VALUE;
    end else if (sel == DR_IDENT && state_q == ST_SHIFT_DR) begin
      id_q <= {tdi, id_q[ID_W-1:1]};
    end
  end

  // Pad levels are unrelated to tck, so they pass the filter first
  pin_sync #(.W(IN_W)) u_in_sync (
    .clk(tck),
    .rst(rst),
    .d(pad_in),
    .q(in_lvl)
  );

  pin_sync #(.W(IO_W)) u_io_sync (
    .clk(tck),
    .rst(rst),
    .d(pad_io_in),
    .q(io_lvl)
  );

  // Pinless cells take the fixed default
  assign capture_vec = {FILL_DEFAULT, io_lvl, in_lvl};

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      bsr_q <= '0;
    end else if (sel == DR_BOUNDARY && state_q == ST_CAP_DR) begin
      bsr_q <= capture_vec;
    end else if (sel == DR_BOUNDARY && state_q == ST_SHIFT_DR) begin
      bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
    end
  end

  // Update stage keeps the drivers steady while new data shifts
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      bsr_upd_q <= '0;
    end else if (sel == DR_BOUNDARY && state_q == ST_UPD_DR) begin
      bsr_upd_q <= bsr_q[FILL_LSB-1:IO_LSB];
    end
  end

  // ==========================================================
  // Serial output
  assign in_shift = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);

  always_comb begin
    serial_out = bypass_q;
    if (state_q == ST_SHIFT_IR) begin
      serial_out = ir_shift_q[0];
    end else if (sel == DR_IDENT) begin
      serial_out = id_q[0];
    end else if (sel == DR_BOUNDARY) begin
      serial_out = bsr_q[0];
    end
  end

  // tdo moves on falling tck, floats outside shifts
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= in_shift ? serial_out : 1'b0;
      tdo_oe_n <= !in_shift;
    end
  end

  // ==========================================================
  // Output drivers in the SRAM clock domain
  pin_sync #(.W(IO_W + 2)) u_ctl_sync (
    .clk(core_clk),
    .rst(rst),
    .d({off_q, extest_q, bsr_upd_q}),
    .q({off_s, extest_s, upd_s})
  );

  // Only drivers are steered; input pins stay with the core
  // Boundary data under EXTEST, float under outputs_off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pad_io_out <= '0;
      pad_io_oe_n <= '1;
    end else if (off_s) begin
      pad_io_out <= '0;
      pad_io_oe_n <= '1;
    end else if (extest_s) begin
      pad_io_out <= upd_s;
      pad_io_oe_n <= '0;
    end else begin
      pad_io_out <= core_dout;
      pad_io_oe_n <= {IO_W{!core_doe}};
    end
  end

  // ==========================================================
  // Checks
  logic [2:0] tms_ones_q;

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      tms_ones_q <= '0;
    end else if (!tms) begin
      tms_ones_q <= '0;
    end else if (tms_ones_q != TMS_RESET_EDGES_3) begin
      tms_ones_q <= tms_ones_q + 3'h1;
    end
  end

  property p_cap_ir;
    @(posedge tck) disable iff (rst)
    state_q == ST_CAP_IR |=> ir_shift_q[1:0] == 2'h1;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong");

  property p_shift_ir;
    @(posedge tck) disable iff (rst)
    state_q == ST_SHIFT_IR |=> ir_shift_q == {$past(tdi), $past(ir_shift_q[2:1])};
  endproperty
  a_shift_ir: assert property (p_shift_ir) else $error("instruction shift wrong");

  property p_ir_hold;
    @(posedge tck) disable iff (rst)
    !(state_q inside {ST_UPD_IR, ST_RESET}) ##1 !(state_q inside {ST_UPD_IR, ST_RESET})
      |-> $stable(ir_q);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction changed early");

  property p_bypass;
    @(posedge tck) disable iff (rst)
    (state_q == ST_SHIFT_DR && sel == DR_BYPASS) |=> bypass_q == $past(tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass cell wrong");

  property p_id_capture;
    @(posedge tck) disable iff (rst)
    (state_q == ST_CAP_DR && ir_q == INSN_IDCODE) |=> id_q == ID_VALUE && id_q[0];
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id capture wrong");

  property p_bsr_capture;
    @(posedge tck) disable iff (rst)
    (state_q == ST_CAP_DR && sel == DR_BOUNDARY)
      |=> bsr_q == $past(capture_vec) && bsr_q[BSR_W-1:FILL_LSB] == FILL_DEFAULT;
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("ring capture wrong");

  property p_tlr_idcode;
    @(posedge tck) disable iff (rst)
    state_q == ST_RESET |=> ir_q == INSN_IDCODE;
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("idcode not default");

  property p_five_ones;
    @(posedge tck) disable iff (rst)
    tms_ones_q == TMS_RESET_EDGES_3 |-> state_q == ST_RESET;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("tms reset missed");

  property p_tdo_float;
    @(posedge tck) disable iff (rst)
    !(state_q inside {ST_SHIFT_IR, ST_SHIFT_DR}) |-> tdo_oe_n;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("tdo driven outside shift");

  property p_tdo_ir;
    @(posedge tck) disable iff (rst)
    state_q == ST_SHIFT_IR |-> !tdo_oe_n && tdo == ir_shift_q[0];
  endproperty
  a_tdo_ir: assert property (p_tdo_ir) else $error("tdo not ir lsb");

  property p_off_float;
    @(posedge core_clk) disable iff (rst)
    off_s |=> pad_io_oe_n == '1;
  endproperty
  a_off_float: assert property (p_off_float) else $error("outputs not floated");

  property p_extest_drive;
    @(posedge core_clk) disable iff (rst)
    (extest_s && !off_s) |=> pad_io_oe_n == '0 && pad_io_out == $past(upd_s);
  endproperty
  a_extest_drive: assert property (p_extest_drive) else $error("extest drive wrong");

  c_id_shift: cover property (@(posedge tck) disable iff (rst)
    state_q == ST_SHIFT_DR && ir_q == INSN_IDCODE);
  c_extest: cover property (@(posedge core_clk) disable iff (rst) extest_s);
  c_off: cover property (@(posedge core_clk) disable iff (rst) off_s);

endmodule
`default_nettype wire

/* sim/jtag_host_model.sv */
// Behavioural scan controller standing on the far side of the test port.
// Assumes one task call at a time; tck rests low between frames.
`timescale 1ns/100ps
`default_nettype none
module jtag_host_model (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  output var logic res_stb,
  output var logic [32:0] res_word
);
  import sram_tap_pkg::*;

  logic ok;
  logic [31:0] got;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    res_stb = 1'b0;
    res_word = '0;
    ok = 1'b1;
    got = '0;
  end

  // ==========================================================
  // Single tck period
  // Inputs move while tck low
  task automatic step(input logic m, input logic d, input logic sh, input int idx);
    logic t;
    tms = m;
    tdi = d;
    #3;
    t = tdo;
    if (tdo_oe_n !== ~sh) ok = 1'b0;
    if (idx >= 0) got[idx] = tdo;
    tck = 1'b1;
    #3;
    if (sh && tdo !== t) ok = 1'b0;
    tck = 1'b0;
  endtask

  task automatic finish_frame();
    res_word = {ok, got};
    res_stb = 1'b1;
    #1;
    res_stb = 1'b0;
    ok = 1'b1;
    got = '0;
  endtask

  // ==========================================================
  // Frames
  // Five tms-high edges, then Idle
  task automatic reset_tap();
    for (int i = 0; i < TMS_RESET_EDGES; i++) step(1'b1, 1'b1, 1'b0, -1);
    step(1'b0, 1'b1, 1'b0, -1);
  endtask

  task automatic idle(input int n);
    for (int i = 0; i < n; i++) step(1'b0, 1'b1, 1'b0, -1);
  endtask

  // From Idle through shift and update back to Idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d);
    step(1'b1, 1'b1, 1'b0, -1);
    if (ir) step(1'b1, 1'b1, 1'b0, -1);
    step(1'b0, 1'b1, 1'b0, -1);
    step(1'b0, 1'b1, 1'b0, -1);
    for (int i = 0; i < n; i++) step(i == n - 1, d[i], 1'b1, i);
    step(1'b1, 1'b1, 1'b0, -1);
    step(1'b0, 1'b1, 1'b0, -1);
    finish_frame();
  endtask
endmodule
`default_nettype wire

/* sim/sram_jtag_tap_instructions_bench.sv */
// Self-checking bench for the SRAM test access port.
// Assumes the scan controller model drives tck; pins resolve from all drivers.
`timescale 1ns/100ps
`default_nettype none
module sram_jtag_tap_instructions_bench;
  import sram_tap_pkg::*;
  localparam logic [2:0] BYP[4] = '{INSN_RESERVED_A, INSN_PRIVATE, INSN_RESERVED_B, INSN_BYPASS};
  localparam logic [2:0] BND[3] = '{INSN_PRELOAD, INSN_EXTEST, INSN_OUTPUTS_OFF};
  localparam logic [32:0] IRCAP = {1'b1, 29'h0, IR_CAPTURE};
  localparam logic [32:0] IDEXP = {1'b1, ID_REVISION, ID_CONFIG, ID_VENDOR, 1'b1};
  logic core_clk, rst, tck, tms, tdi, tdo, tdo_oe_n, core_doe, res_stb, pad_stb;
  logic [IN_W-1:0] pad_in;
  logic [IO_W-1:0] ext_io, pad_io_in, pad_io_out, pad_io_oe_n, core_dout, drv, io;
  logic [32:0] res_word;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [31:0] d;
  int err_total, num_checks;

  // Wire level from whoever drives it
  assign pad_io_in = (~pad_io_oe_n & pad_io_out) | (pad_io_oe_n & ext_io);

  sram_tap sram_tap_inst (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pad_in(pad_in), .pad_io_in(pad_io_in),
    .pad_io_out(pad_io_out), .pad_io_oe_n(pad_io_oe_n), .core_dout(core_dout),
    .core_doe(core_doe));
  jtag_host_model jtag_host_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .res_stb(res_stb), .res_word(res_word));

  always #(CORE_CLK_NS / 2) core_clk = ~core_clk;

  // ==========================================================
  // Checking
  task automatic note(input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask

  task automatic pad_check(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] om);
    note({17'h0, oe, o}, {17'h0, 8'hff, om});
    pad_stb = 1'b1;
    #1;
    pad_stb = 1'b0;
  endtask

  always @(posedge res_stb or posedge pad_stb) begin
    logic [32:0] g, e, m;
    g = res_stb ? res_word : {17'h0, pad_io_oe_n, pad_io_out};
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    num_checks++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic set_pads(input logic doe);
    @(negedge core_clk);
    pad_in = IN_W'($urandom);
    ext_io = IO_W'($urandom);
    core_dout = IO_W'($urandom);
    core_doe = doe;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  // ==========================================================
  // Scenarios
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    pad_in = '0;
    ext_io = '0;
    core_dout = '0;
    core_doe = 1'b0;
    pad_stb = 1'b0;
    drv = '0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(32'hb3b8));
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    jtag_host_model_inst.reset_tap();
    note(IDEXP, '1);
    jtag_host_model_inst.scan(1'b0, ID_W, $urandom);
    // Reserved codes used here only to show they bypass
    foreach (BYP[i]) begin
      d = $urandom;
      note(IRCAP, '1);
      jtag_host_model_inst.scan(1'b1, IR_W, {29'h0, BYP[i]});
      note({1'b1, 30'h0, d[0], 1'b0}, '1);
      jtag_host_model_inst.scan(1'b0, 2, d);
    end
    foreach (BND[i]) begin
      note(IRCAP, '1);
      jtag_host_model_inst.scan(1'b1, IR_W, {29'h0, BND[i]});
      set_pads(1'b0);
      repeat (10) @(negedge core_clk);
      jtag_host_model_inst.idle(6);
      io = (BND[i] == INSN_EXTEST) ? drv : ext_io;
      d = $urandom;
      note({1'b1, 18'h0, FILL_DEFAULT, io, pad_in}, '1);
      jtag_host_model_inst.scan(1'b0, BSR_W, d);
      drv = d[FILL_LSB-1:IO_LSB];
      repeat (10) @(negedge core_clk);
      if (BND[i] == INSN_EXTEST) pad_check(8'h00, drv, 8'hff);
      else pad_check(8'hff, 8'h00, 8'h00);
    end
    note(IRCAP, '1);
    jtag_host_model_inst.scan(1'b1, IR_W, {29'h0, INSN_BYPASS});
    jtag_host_model_inst.reset_tap();
    note(IDEXP, '1);
    jtag_host_model_inst.scan(1'b0, ID_W, 32'hffffffff);
    set_pads(1'b1);
    repeat (10) @(negedge core_clk);
    pad_check(8'h00, core_dout, 8'hff);
    print_verdict();
  end
endmodule
`default_nettype wire
